// >>> spidm_core.v
// Purpose: Serial peripheral interface as it behaves on an early revision
// Assumes: One clock mclk at 50 MHz; configuration arrives as plain ports
// Notes:   Slave pins are sampled through two flip-flops before any use
`timescale 1ns/1ps
`include "spidm_regs.vh"

// Contract
// - The divided clock option misbehaves when set, so software must leave it at zero.
// - No transmit underrun flag exists, so a lost slave character is never reported.
// - Multiple selects, polarity 1, phase 0, one divisor 1 and another not 1 gives an extra pulse.
// - In slave mode a false receive-ready may appear at enable, until a first received character or a polarity toggle.
// - The release-after-transfer bit of the select configurations does nothing.
// - Disable has no effect in slave mode; reading data then a software reset stops it.
module spidm_core #(
	parameter CS_N = 4
) (
	// Clock and reset
	input  wire                 mclk,
	input  wire                 srst,
	// Control
	input  wire                 sw_reset,
	input  wire                 enable_set,
	input  wire                 disable_set,
	input  wire                 master_mode_in,
	input  wire                 mode_write,
	input  wire                 clock_divide_select,
	input  wire [CS_N*16-1:0]   chip_select_config_registers,
	input  wire [1:0]           cs_select,
	input  wire                 start_tx,
	input  wire [7:0]           tx_data,
	input  wire                 rx_read,
	// Status
	output reg  [7:0]           receive_holding_register,
	output reg                  receive_ready_flag,
	output reg                  spi_enabled,
	output reg                  master_mode,
	output reg                  busy,
	// Serial pins
	input  wire                 sck_in,
	output reg                  sck_out,
	output wire                 sck_oe_n,
	input  wire                 mosi_in,
	output reg                  mosi_out,
	output wire                 mosi_oe_n,
	input  wire                 miso_in,
	output reg                  miso_out,
	output wire                 miso_oe_n,
	input  wire                 cs_in_n,
	output reg  [CS_N-1:0]      cs_out_n
);

	// ------------------------------------------------------------------------
	// Field decoding
	// ------------------------------------------------------------------------
	function [7:0] baud_of;
		input [CS_N*16-1:0] cfg;
		input integer       idx;
		begin
			baud_of = cfg[idx*16+`SPIDM_CSCFG_BAUD_LSB +: 8];
		end
	endfunction

	function cpol_of;
		input [CS_N*16-1:0] cfg;
		input integer       idx;
		begin
			cpol_of = cfg[idx*16+`SPIDM_CSCFG_CPOL];
		end
	endfunction

	wire [7:0] cur_baud = baud_of(chip_select_config_registers, cs_select);
	wire       cur_cpol = cpol_of(chip_select_config_registers, cs_select);
	wire       cur_ncph = chip_select_config_registers[cs_select*16+`SPIDM_CSCFG_NCPH];
	// Release-after-transfer bit is not read anywhere: select drops after every char

	// Mixed divisor detection across all selects
	wire [CS_N-1:0] baud_is_one;
	genvar gi;
	generate
		for (gi = 0; gi < CS_N; gi = gi + 1) begin : g_baud
			assign baud_is_one[gi] =
				chip_select_config_registers[gi*16+`SPIDM_CSCFG_BAUD_LSB +: 8]
				== `SPIDM_BAUD_ONE;
		end
	endgenerate
	wire mixed_baud = (|baud_is_one) && !(&baud_is_one);
	wire extra_pulse_cfg = mixed_baud && cur_cpol && !cur_ncph;

	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------
	// Master samples the far side's data line only after both stages
	reg [1:0] sck_s_q, mosi_s_q, miso_s_q, csn_s_q;
	reg       sck_prev_q;
	always @(posedge mclk) begin
		sck_s_q  <= {sck_s_q[0], sck_in};
		mosi_s_q <= {mosi_s_q[0], mosi_in};
		miso_s_q <= {miso_s_q[0], miso_in};
		csn_s_q  <= {csn_s_q[0], cs_in_n};
		sck_prev_q <= sck_s_q[1];
	end

	// ------------------------------------------------------------------------
	// Mode and enable
	// ------------------------------------------------------------------------
	reg cpol_prev_q;
	reg armed_q;
	always @(posedge mclk) begin
		if (srst || sw_reset) begin
			spi_enabled <= `SPIDM_ENABLE_RST;
			master_mode <= `SPIDM_MASTER_RST;
		end else begin
			if (mode_write)
				master_mode <= master_mode_in;
			if (enable_set)
				spi_enabled <= 1'b1;
			else if (disable_set && master_mode)
				spi_enabled <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Master and slave shift engines
	// ------------------------------------------------------------------------
	// Nine bits: the doubled half period of the divide option reaches 510
	reg [8:0] div_q;
	reg [4:0] edge_q;
	reg [7:0] sh_q;
	reg       extra_q;
	reg [3:0] sbit_q;
	reg [7:0] ssh_q;
	wire      slave_sck_rise = sck_s_q[1] && !sck_prev_q;
	wire      slave_active   = spi_enabled && !master_mode && !csn_s_q[1];
	// Doubling keeps the ninth bit so a large divisor cannot wrap to a short period
	wire [8:0] half = (clock_divide_select == `SPIDM_CLOCK_DIVIDE_SELECT_BROKEN) ?
		{cur_baud, 1'b0} : {1'b0, cur_baud};
	wire       step_now  = (div_q + 9'h001) >= half;
	wire [4:0] last_edge = extra_q ? `SPIDM_EDGE_LAST_X : `SPIDM_EDGE_LAST;
	wire       m_done    = busy && step_now && (edge_q == last_edge);
	wire       s_done    = slave_active && slave_sck_rise && (sbit_q == `SPIDM_SBIT_LAST);
	// Spurious ready at enable in slave mode until the polarity toggle or the first received character
	wire       spur_set  = !master_mode && enable_set && !armed_q;
	wire       rdy_set   = m_done || s_done || spur_set;

	always @(posedge mclk) begin
		if (srst || sw_reset) begin
			div_q    <= 9'h000;
			edge_q   <= 5'h00;
			sh_q     <= 8'h00;
			busy     <= 1'b0;
			extra_q  <= 1'b0;
			sck_out  <= 1'b0;
			mosi_out <= 1'b0;
			cs_out_n <= {CS_N{1'b1}};
			receive_holding_register <= 8'h00;
			receive_ready_flag <= 1'b0;
			sbit_q   <= `SPIDM_BITCNT_RST;
			ssh_q    <= 8'h00;
			miso_out <= 1'b0;
			cpol_prev_q <= 1'b0;
			armed_q  <= 1'b0;
		end else begin
			cpol_prev_q <= cur_cpol;
			if (!busy)
				sck_out <= cur_cpol;
			// Master transfer start
			if (master_mode && spi_enabled && start_tx && !busy) begin
				busy     <= 1'b1;
				sh_q     <= tx_data;
				mosi_out <= tx_data[7];
				edge_q   <= 5'h00;
				div_q    <= 9'h000;
				extra_q  <= extra_pulse_cfg;
				cs_out_n <= ~({{(CS_N-1){1'b0}}, 1'b1} << cs_select);
			end else if (busy) begin
				if (step_now) begin
					div_q   <= 9'h000;
					sck_out <= ~sck_out;
					edge_q  <= edge_q + 5'h01;
					if (edge_q[0]) begin
						sh_q     <= {sh_q[6:0], miso_s_q[1]};
						mosi_out <= sh_q[6];
					end
					// Extra clock pair tacked on when divisors are mixed and this select has polarity 1, phase 0
					if (m_done) begin
						busy     <= 1'b0;
						cs_out_n <= {CS_N{1'b1}};
						receive_holding_register <= {sh_q[6:0], miso_s_q[1]};
					end
				end else
					div_q <= div_q + 9'h001;
			end
			// Slave receive; lost transmit characters raise nothing
			if (slave_active && slave_sck_rise) begin
				ssh_q  <= {ssh_q[6:0], mosi_s_q[1]};
				sbit_q <= sbit_q + 4'h1;
				miso_out <= tx_data[3'h6 - sbit_q[2:0]];
				if (s_done) begin
					sbit_q <= `SPIDM_BITCNT_RST;
					receive_holding_register <= {ssh_q[6:0], mosi_s_q[1]};
					armed_q <= 1'b1;
				end
			end
			if (!master_mode && spi_enabled && cpol_prev_q != cur_cpol)
				armed_q <= 1'b1;
			// Set beats clear, so a character landing with the read is kept
			if (rdy_set)
				receive_ready_flag <= 1'b1;
			else if (rx_read)
				receive_ready_flag <= 1'b0;
		end
	end

	// Miso is driven only while this side is the selected slave
	assign sck_oe_n  = !(master_mode && spi_enabled);
	assign mosi_oe_n = !(master_mode && spi_enabled);
	assign miso_oe_n = !slave_active;

endmodule // spidm_core

// >>> spidm_core_sva.sv
// Purpose: Port assertions for spidm_core
// Assumes: One clock mclk, srst synchronous
// Notes:   Bound into every spidm_core instance
`timescale 1ns/1ps
module spidm_core_sva #(parameter CS_N = 4) (
	input wire            mclk, srst, sw_reset, disable_set, start_tx, rx_read,
	input wire            clock_divide_select, receive_ready_flag, spi_enabled,
	input wire            master_mode, busy, enable_set,
	input wire [1:0]      cs_select,
	input wire [CS_N*16-1:0] chip_select_config_registers,
	input wire [CS_N-1:0] cs_out_n
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst || sw_reset);
	logic [15:0] busy_len_q;
	wire  [7:0]  div_sel  = chip_select_config_registers[cs_select*16+8 +: 8];
	wire  [15:0] half_cyc = (div_sel == 8'h00) ? 16'h0001 : {8'h00, div_sel};
	always @(posedge mclk)
		if (srst || sw_reset || !busy)
			busy_len_q <= 16'h0000;
		else
			busy_len_q <= busy_len_q + 16'h0001;
	sequence frame_end;
		!busy && (&cs_out_n) && receive_ready_flag;
	endsequence
	sequence busy_run;
		busy[*8];
	endsequence
	rst_state_a: assert property (disable iff (1'b0) (srst || sw_reset) |=> !spi_enabled
		&& master_mode && !busy && (&cs_out_n) && !receive_ready_flag) else $error("reset state");
	frame_done_a: assert property ($rose(busy) && master_mode |-> busy_run)
		else $error("frame too short");
	frame_end_a: assert property ($fell(busy) && !$past(srst) && !$past(sw_reset) |-> frame_end)
		else $error("frame end wrong");
	half_len_a: assert property ($fell(busy) && !clock_divide_select && !$past(srst)
		&& !$past(sw_reset) |-> busy_len_q == (half_cyc << 4)
		|| busy_len_q == (half_cyc << 4) + (half_cyc << 1))
		else $error("frame length");
	start_take_a: assert property (start_tx && master_mode && spi_enabled && !busy
		|=> busy && !(&cs_out_n)) else $error("start not taken");
	ready_hold_a: assert property (receive_ready_flag && !rx_read |=> receive_ready_flag)
		else $error("ready lost");
	read_clear_a: assert property (rx_read && master_mode && !busy |=> !receive_ready_flag)
		else $error("ready not cleared");
	slave_dis_a: assert property (disable_set && !enable_set && !master_mode |=> $stable(spi_enabled))
		else $error("slave disable acted");
endmodule // spidm_core_sva
bind spidm_core spidm_core_sva #(.CS_N(CS_N)) u_sva (.*);

// >>> spidm_core_test.sv
// Purpose: Self-checking bench for spidm_core
// Assumes: 50 MHz mclk, peer on select 0
// Notes:   Every master transfer also tries a refused start while busy
`timescale 1ns/1ps
module spidm_core_test;
	reg        mclk = 0, srst = 1, sw_reset = 0, enable_set = 0, disable_set = 0, rx_read = 0;
	reg        master_mode_in = 1, mode_write = 0, start_tx = 0;
	reg        clock_divide_select = 0;
	reg [1:0]  cs_select = 0;
	reg [7:0]  tx_data = 0;
	reg [63:0] chip_select_config_registers = 0;
	wire [7:0] receive_holding_register;
	wire [3:0] cs_out_n;
	wire       receive_ready_flag, spi_enabled, master_mode, busy, sck_in, sck_out, sck_oe_n;
	wire       mosi_in, mosi_out, mosi_oe_n, miso_in, miso_out, miso_oe_n, cs_in_n;
	integer    err_total = 0, compares = 0, cyc = 0;
	spidm_core DUT (.*);
	spidm_peer u_peer (.*);
	initial forever #10 mclk = ~mclk;
	task report_and_stop;
		begin
			$display("errors %0d compares %0d", err_total, compares);
			if (err_total == 0 && compares > 0) $display("Testbench passed");
			else $display("Testbench failed");
			$finish;
		end
	endtask
	always @(posedge mclk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			report_and_stop;
		end
	end
	task chk(input [31:0] nm, input [7:0] e, input [7:0] g);
		begin
			compares = compares + 1;
			if (g !== e) begin
				err_total = err_total + 1;
				$display("BAD %s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge mclk);
	endtask
	// Second start lands while busy and must be dropped
	task xfer(input [7:0] d, input [15:0] c0, input [15:0] c1);
		begin
			chip_select_config_registers <= {c1, c1, c1, c0};
			tx_data <= d;
			start_tx <= 1;
			tick(1); start_tx <= 0;
			tick(1); start_tx <= 1;
			tick(1); start_tx <= 0;
			repeat (600) begin
				@(posedge mclk);
				#1 if (busy !== 1'b1) break;
			end
			tick(2);
			#1;
		end
	endtask
	initial begin
		tick(12); srst <= 0;
		tick(2); #1;
		chk("mode", 8'h01, master_mode);
		chk("csel", 8'h0F, cs_out_n);
		tick(1); enable_set <= 1;
		tick(1); enable_set <= 0;
		tick(1); xfer(8'hA5, 16'h0202, 16'h0000);
		chk("mosi", 8'hA5, u_peer.rx);
		chk("edge", 8'h10, u_peer.tg);
		chk("rhr ", 8'h3C, receive_holding_register);
		chk("csel", 8'h0F, cs_out_n);
		chk("busy", 8'h00, busy);
		chk("scoe", 8'h00, sck_oe_n);
		chk("mooe", 8'h00, mosi_oe_n);
		chk("rdy ", 8'h01, receive_ready_flag);
		tick(1); rx_read <= 1;
		tick(1); rx_read <= 0;
		xfer(8'h81, 16'h0101, 16'h0201);
		chk("edge", 8'h12, u_peer.tg);
		tick(1); xfer(8'h81, 16'h0101, 16'h0101);
		chk("edge", 8'h10, u_peer.tg);
		tick(1); sw_reset <= 1;
		tick(1); sw_reset <= 0; master_mode_in <= 0; mode_write <= 1;
		chip_select_config_registers <= 64'h0;
		tick(1); mode_write <= 0; enable_set <= 1;
		tick(1); enable_set <= 0; chip_select_config_registers <= 64'h1;
		tick(1); chip_select_config_registers <= 64'h0; rx_read <= 1;
		tick(1); rx_read <= 0;
		tick(2); #1 chk("rdy ", 8'h00, receive_ready_flag);
		u_peer.send(8'h5A);
		tick(8); #1 chk("rdy ", 8'h01, receive_ready_flag);
		chk("rhr ", 8'h5A, receive_holding_register);
		chk("scoe", 8'h01, sck_oe_n);
		chk("mioe", 8'h01, miso_oe_n);
		chk("miso", 8'h01, miso_out);
		tick(1); disable_set <= 1;
		tick(1); disable_set <= 0;
		tick(1); #1 chk("en  ", 8'h01, spi_enabled);
		tick(1); rx_read <= 1;
		tick(1); rx_read <= 0; sw_reset <= 1;
		tick(1); sw_reset <= 0;
		tick(1); #1 chk("en  ", 8'h00, spi_enabled);
		chk("mode", 8'h01, master_mode);
		report_and_stop;
	end
endmodule // spidm_core_test

// >>> spidm_peer.sv
// Purpose: Far-side serial device: slave in master mode, master in slave mode
// Assumes: Select 0 only, clock polarity 0 for data
// Notes:   Idle miso toggles and mosi ends inverted so no stale bit can pass
`timescale 1ns/1ps
module spidm_peer (
	input wire       mclk, sck_out, mosi_out,
	input wire [3:0] cs_out_n,
	output reg       sck_in = 0, mosi_in = 0, cs_in_n = 1,
	output wire      miso_in
);
	reg       s = 0, c = 1, t = 0;
	reg [7:0] pat = 8'h3C, rx = 8'h00, tg = 8'h00;
	integer   i;
	assign miso_in = cs_out_n[0] ? t : pat[7];
	always @(posedge mclk) begin
		s <= sck_out;
		c <= cs_out_n[0];
		t <= ~t;
		if (c && !cs_out_n[0]) tg <= 8'h00;
		else if (s !== sck_out) tg <= tg + 8'h01;
		if (cs_out_n[0]) pat <= 8'h3C;
		else if (s !== sck_out && sck_out) rx <= {rx[6:0], mosi_out};
		else if (s !== sck_out) pat <= {pat[6:0], 1'b0};
	end
	task send(input [7:0] d);
		begin
			@(posedge mclk) cs_in_n <= 0;
			for (i = 7; i >= 0; i = i - 1) begin
				mosi_in <= d[i];
				repeat (6) @(posedge mclk);
				sck_in <= 1;
				repeat (6) @(posedge mclk);
				sck_in <= 0;
			end
			repeat (6) @(posedge mclk);
			cs_in_n <= 1;
			mosi_in <= ~d[0];
		end
	endtask
endmodule // spidm_peer

// >>> spidm_regs.vh
// Purpose: Constants for the serial interface defect model
// Assumes: Included by spidm_core.v only
// Notes:   Offsets and field positions of the control word ports
`ifndef SPIDM_REGS_VH
`define SPIDM_REGS_VH

// ----------------------------------------------------------------------------
// Chip select configuration fields
// ----------------------------------------------------------------------------
`define SPIDM_CS_COUNT        4
`define SPIDM_CSCFG_CPOL      0
`define SPIDM_CSCFG_NCPH      1
`define SPIDM_CSCFG_RELEASE   2
`define SPIDM_CSCFG_BAUD_LSB  8
`define SPIDM_CSCFG_BAUD_MSB  15
`define SPIDM_CSCFG_RST       16'h0000
`define SPIDM_BAUD_ONE        8'h01

// ----------------------------------------------------------------------------
// Mode and reset values
// ----------------------------------------------------------------------------
`define SPIDM_CLOCK_DIVIDE_SELECT_BROKEN     1'b1
`define SPIDM_MASTER_RST      1'b1
`define SPIDM_ENABLE_RST      1'b0
`define SPIDM_CHAR_BITS       8
`define SPIDM_BITCNT_RST      4'h0
`define SPIDM_SBIT_LAST       4'h7
`define SPIDM_EDGE_LAST       5'h0F
`define SPIDM_EDGE_LAST_X     5'h11

`endif
